// *** verilog/dps_seq_map.vh ***
// Purpose: constants for the deposition process sequencer
// Assumes: 250 MHz ref_clk
// Notes: long counts are also module parameters so a bench can shorten them
`ifndef DPS_SEQ_MAP_VH
`define DPS_SEQ_MAP_VH
// coating threshold, degrees C, on the 10-bit vaporizer temperature input
`define DPS_COAT_TEMP_C 10'h05a
// clock rate in Hz
`define DPS_CLK_HZ 250000000
// fault grace and end-of-run times, in seconds (5 minutes)
`define DPS_FAULT_TIME_S 300
`define DPS_EOR_TIME_S 300
// derived cycle counts, 40 bits to match the timer width (the product fits)
`define DPS_FAULT_CYC (40'd300 * 40'd250000000)
`define DPS_EOR_CYC (40'd300 * 40'd250000000)
// blink half period: 0.5 s
`define DPS_BLINK_CYC (40'd250000000 / 40'd2)
// sequencer states
`define DPS_ST_IDLE 3'h0
`define DPS_ST_HEAT 3'h1
`define DPS_ST_RAMP 3'h2
`define DPS_ST_COAT 3'h3
`define DPS_ST_HOLD 3'h4
`define DPS_ST_SHUT 3'h5
`endif

// *** verilog/dps_timer.v ***
// Purpose: resettable down-count timer with expiry flag
// Assumes: synchronous active-high reset, clock enable gates all state
// Notes: expiry stays high until the timer is cleared
`timescale 1ns/1ns
module dps_timer #(
	parameter [39:0] LOAD = 40'h0000000010
) (
	// clock and control
	input wire ref_clk,
	input wire srst,
	input wire clkEn,
	// run is a level: low clears the timer
	input wire run,
	// expired flag
	output reg expired
);
	// remaining count
	reg [39:0] count_ff;
	// count down while run is held, reload when it drops
	always @(posedge ref_clk) begin
		if (srst) begin
			// start loaded so a run raised right after reset still waits the full time
			count_ff <= LOAD;
			expired <= 1'b0;
		end else if (clkEn) begin
			if (!run) begin
				count_ff <= LOAD;
				expired <= 1'b0;
			end else if (count_ff <= 40'h1) begin
				// reached: latch expiry until run falls
				expired <= 1'b1;
			end else begin
				count_ff <= count_ff - 40'h1;
			end
		end
	end
endmodule // dps_timer

// *** verilog/dps_sequencer.v ***
// Purpose: supervisory sequencer for a vacuum deposition run
// Assumes: all inputs synchronous to ref_clk; buttons are one-cycle presses
// Notes: APB slave holds control, status and interrupt registers
// Overview of operation
// - start: furnace/gauge heat, fault watch, rotation
// - vaporizer ramps after base pressure, temps in limits
// - coating begins above coating threshold
// - fault: flash red, sound alarm, start timer
// - alarm button silences audio alarm
// - fault persisting at timer expiry shuts down
// - run done: hold vaporizer, end-of-run timer, shutdown
// - shutdown blinks green, disables all heaters
// - fault shutdown turns red lamp steady
// - pump stays on during shutdown
// - start button or vent ends vacuum hold
// - semi-auto: vaporizer heats only when interlocked
// - semi-auto: unresolved alarm kills heaters after timeout
//
// The implementer's own choices: the APB slave port and the address map.
`timescale 1ns/1ns
`include "dps_seq_map.vh"
module dps_sequencer #(
	parameter [39:0] FAULT_CYC = `DPS_FAULT_CYC,
	parameter [39:0] EOR_CYC = `DPS_EOR_CYC,
	parameter [39:0] BLINK_CYC = `DPS_BLINK_CYC
) (
	// clock, reset, enable
	input wire ref_clk,
	input wire srst,
	input wire clkEn,
	// apb slave
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [7:0] paddr,
	input wire [31:0] pwdata,
	output reg [31:0] prdata,
	output reg pready,
	output reg pslverr,
	// operator panel
	input wire startStopPress,
	input wire alarmPress,
	input wire ventSelect,
	input wire semiAuto,
	input wire rotationFitted,
	// process controller flags
	input wire basePressureLamp,
	input wire furnaceLimitLamp,
	input wire gaugeLimitLamp,
	input wire pumpDownElapsed,
	input wire runComplete,
	input wire tempFault,
	input wire [9:0] vapTempC,
	// semi-auto manual enables
	input wire manFurnaceEn,
	input wire manVapEn,
	input wire manRotateEn,
	// outputs, all registered
	output reg furnaceHeatEn,
	output reg gaugeHeatEn,
	output reg vapHeatEn,
	output reg loadDoorHeatEn,
	output reg vapLamp,
	output reg rotateEn,
	output reg pumpOn,
	output reg redLamp,
	output reg audioAlarm,
	output reg greenLamp,
	output reg irq
);
	// register offsets
	localparam [7:0] OFS_CTRL = 8'h00;
	localparam [7:0] OFS_STATE = 8'h04;
	localparam [7:0] OFS_IRQ_STAT = 8'h08;
	localparam [7:0] OFS_IRQ_EN = 8'h0c;
	localparam [7:0] OFS_IRQ_CLR = 8'h10;

	// sequencer state and flags
	reg [2:0] state_ff;
	reg [2:0] nxt_state;
	reg faultCause_ff;
	reg silenced_ff;
	reg blink_ff;
	reg [39:0] blinkCnt_ff;
	reg semiTrip_ff;
	// control register: bit0 software start, bit1 software stop, bit2 door heat
	reg doorHeatReq_ff;
	reg [3:0] irqStat_ff;
	reg [3:0] irqEn_ff;

	// bus decode: zero wait state, access phase only
	wire apbAcc = psel && penable;
	wire apbWr = apbAcc && pwrite;
	wire swStart = apbWr && (paddr == OFS_CTRL) && pwdata[0];
	wire swStop = apbWr && (paddr == OFS_CTRL) && pwdata[1];
	wire startEv = startStopPress || swStart;
	wire running = (state_ff != `DPS_ST_IDLE) && (state_ff != `DPS_ST_SHUT);
	// temps in limits when neither controller limit lamp flashes
	wire tempsOk = !furnaceLimitLamp && !gaugeLimitLamp;
	wire interlockOk = basePressureLamp && tempsOk;
	// fault is watched once the run is armed, and at any time in semi-auto
	wire faultActive = tempFault && running;
	wire semiFault = semiAuto && tempFault;

	// timers
	wire faultExp;
	wire eorExp;
	// fault timer, cleared with the fault
	dps_timer #(.LOAD(FAULT_CYC)) uFaultTmr (
		.ref_clk(ref_clk),
		.srst(srst),
		.clkEn(clkEn),
		.run(faultActive || semiFault),
		.expired(faultExp)
	);
	// end-of-run timer runs only in hold
	dps_timer #(.LOAD(EOR_CYC)) uEorTmr (
		.ref_clk(ref_clk),
		.srst(srst),
		.clkEn(clkEn),
		.run(state_ff == `DPS_ST_HOLD),
		.expired(eorExp)
	);

	// next state; the fault path wins over normal progress
	always @* begin
		nxt_state = state_ff;
		case (state_ff)
			`DPS_ST_IDLE: begin
				if (startEv && !semiAuto)
					nxt_state = `DPS_ST_HEAT;
			end
			`DPS_ST_HEAT: begin
				if (interlockOk)
					nxt_state = `DPS_ST_RAMP;
			end
			`DPS_ST_RAMP: begin
				if (vapTempC > `DPS_COAT_TEMP_C)
					nxt_state = `DPS_ST_COAT;
			end
			`DPS_ST_COAT: begin
				if (runComplete)
					nxt_state = `DPS_ST_HOLD;
			end
			`DPS_ST_HOLD: begin
				if (eorExp)
					nxt_state = `DPS_ST_SHUT;
			end
			`DPS_ST_SHUT: begin
				// button or vent leaves vacuum hold
				if (startEv || ventSelect)
					nxt_state = `DPS_ST_IDLE;
			end
			default: nxt_state = `DPS_ST_IDLE;
		endcase
		if (running && faultExp && tempFault)
			nxt_state = `DPS_ST_SHUT;
		// software stop aborts to shutdown
		if (running && swStop)
			nxt_state = `DPS_ST_SHUT;
	end

	// state, fault cause and silence latch
	always @(posedge ref_clk) begin
		if (srst) begin
			state_ff <= `DPS_ST_IDLE;
			faultCause_ff <= 1'b0;
			silenced_ff <= 1'b0;
			semiTrip_ff <= 1'b0;
		end else if (clkEn) begin
			state_ff <= nxt_state;
			if (running && nxt_state == `DPS_ST_SHUT)
				faultCause_ff <= faultExp && tempFault;
			else if (nxt_state == `DPS_ST_IDLE)
				faultCause_ff <= 1'b0;
			// silence latch; rearms when fault clears
			if (!tempFault)
				silenced_ff <= 1'b0;
			else if (alarmPress)
				silenced_ff <= 1'b1;
			// semi-auto trip holds until mode left
			if (!semiAuto)
				semiTrip_ff <= 1'b0;
			else if (semiFault && faultExp)
				semiTrip_ff <= 1'b1;
		end
	end

	// blink generator, shared by red flash and green blink
	always @(posedge ref_clk) begin
		if (srst) begin
			blinkCnt_ff <= 40'h0;
			blink_ff <= 1'b0;
		end else if (clkEn) begin
			if (blinkCnt_ff >= BLINK_CYC - 40'h1) begin
				blinkCnt_ff <= 40'h0;
				blink_ff <= !blink_ff;
			end else begin
				blinkCnt_ff <= blinkCnt_ff + 40'h1;
			end
		end
	end

	// output drivers; outside semi-auto all heater enables derive from the next state
	always @(posedge ref_clk) begin
		if (srst) begin
			furnaceHeatEn <= 1'b0;
			gaugeHeatEn <= 1'b0;
			vapHeatEn <= 1'b0;
			loadDoorHeatEn <= 1'b0;
			vapLamp <= 1'b0;
			rotateEn <= 1'b0;
			pumpOn <= 1'b0;
			redLamp <= 1'b0;
			audioAlarm <= 1'b0;
			greenLamp <= 1'b0;
		end else if (clkEn) begin
			if (semiAuto) begin
				furnaceHeatEn <= manFurnaceEn && !semiTrip_ff;
				gaugeHeatEn <= manFurnaceEn && !semiTrip_ff;
				vapLamp <= manVapEn;
				// vaporizer heats only with interlocks met
				vapHeatEn <= manVapEn && interlockOk && pumpDownElapsed && !semiTrip_ff;
				loadDoorHeatEn <= doorHeatReq_ff && !semiTrip_ff;
				rotateEn <= manRotateEn && rotationFitted;
				pumpOn <= 1'b1;
				redLamp <= semiTrip_ff ? 1'b1 : (tempFault && blink_ff);
				audioAlarm <= tempFault && !silenced_ff;
				greenLamp <= 1'b0;
			end else begin
				// furnace and gauge heat once armed
				furnaceHeatEn <= (nxt_state != `DPS_ST_IDLE) && (nxt_state != `DPS_ST_SHUT);
				gaugeHeatEn <= (nxt_state != `DPS_ST_IDLE) && (nxt_state != `DPS_ST_SHUT);
				// vaporizer disabled in heat; held at setpoint in hold
				vapHeatEn <= (nxt_state == `DPS_ST_RAMP) || (nxt_state == `DPS_ST_COAT) ||
					(nxt_state == `DPS_ST_HOLD);
				vapLamp <= (nxt_state == `DPS_ST_RAMP) || (nxt_state == `DPS_ST_COAT) ||
					(nxt_state == `DPS_ST_HOLD);
				loadDoorHeatEn <= doorHeatReq_ff && (nxt_state != `DPS_ST_SHUT);
				rotateEn <= rotationFitted && (nxt_state != `DPS_ST_IDLE) &&
					(nxt_state != `DPS_ST_SHUT);
				// pump on through run and shutdown
				pumpOn <= (nxt_state != `DPS_ST_IDLE);
				// flash red while fault, steady after fault shutdown
				if (nxt_state == `DPS_ST_SHUT)
					redLamp <= faultCause_ff || (running && faultExp && tempFault);
				else
					redLamp <= faultActive && blink_ff;
				audioAlarm <= faultActive && !silenced_ff && !alarmPress;
				// blink green in shutdown, steady while running
				if (nxt_state == `DPS_ST_SHUT)
					greenLamp <= blink_ff;
				else
					greenLamp <= (nxt_state != `DPS_ST_IDLE);
			end
		end
	end

	// interrupt events: bit0 fault, bit1 coating, bit2 shutdown, bit3 run done
	wire [3:0] irqEv;
	assign irqEv[0] = tempFault && !audioAlarm && !silenced_ff && (running || semiAuto);
	assign irqEv[1] = (state_ff == `DPS_ST_RAMP) && (nxt_state == `DPS_ST_COAT);
	assign irqEv[2] = running && (nxt_state == `DPS_ST_SHUT);
	assign irqEv[3] = (state_ff == `DPS_ST_COAT) && (nxt_state == `DPS_ST_HOLD);
	wire irqClrWr = apbWr && (paddr == OFS_IRQ_CLR);

	// apb registers; a set wins over a clear in the same cycle
	always @(posedge ref_clk) begin
		if (srst) begin
			doorHeatReq_ff <= 1'b0;
			irqStat_ff <= 4'h0;
			irqEn_ff <= 4'h0;
			prdata <= 32'h0;
			pready <= 1'b0;
			pslverr <= 1'b0;
			irq <= 1'b0;
		end else if (clkEn) begin
			pready <= psel && !penable;
			pslverr <= 1'b0;
			irqStat_ff <= (irqStat_ff & ~(irqClrWr ? pwdata[3:0] : 4'h0)) | irqEv;
			irq <= |(irqStat_ff & irqEn_ff);
			if (psel && !penable) begin
				// setup phase: decode and stage read data
				prdata <= 32'h0;
				case (paddr)
					OFS_CTRL: prdata <= {29'h0, doorHeatReq_ff, 2'h0};
					OFS_STATE: prdata <= {21'h0, faultCause_ff, silenced_ff, semiTrip_ff,
						redLamp, audioAlarm, greenLamp, vapHeatEn, 1'b0, state_ff};
					OFS_IRQ_STAT: prdata <= {28'h0, irqStat_ff};
					OFS_IRQ_EN: prdata <= {28'h0, irqEn_ff};
					OFS_IRQ_CLR: prdata <= 32'h0;
					default: pslverr <= 1'b0;
				endcase
				if (paddr > OFS_IRQ_CLR || paddr[1:0] != 2'h0)
					pslverr <= 1'b1;
			end
			if (apbWr && paddr == OFS_CTRL)
				doorHeatReq_ff <= pwdata[2];
			if (apbWr && paddr == OFS_IRQ_EN)
				irqEn_ff <= pwdata[3:0];
			if (apbAcc && pready)
				pready <= 1'b0;
		end
	end
endmodule // dps_sequencer

// *** test/dps_seq_checker.sv ***
// Purpose: port-level checks of the sequencer
// Assumes: one ref_clk domain, srst synchronous active high
// Notes: outputs lag their cause by one edge
`timescale 1ns/1ns
module dps_seq_checker #(
	parameter [39:0] FAULT_CYC = 40'h1,
	parameter [39:0] EOR_CYC = 40'h1,
	parameter [39:0] BLINK_CYC = 40'h1
) (
	// clock and control
	input wire ref_clk,
	input wire srst,
	input wire clkEn,
	// apb request
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [7:0] paddr,
	input wire [31:0] pwdata,
	// panel and plant
	input wire startStopPress,
	input wire alarmPress,
	input wire semiAuto,
	input wire basePressureLamp,
	input wire furnaceLimitLamp,
	input wire gaugeLimitLamp,
	input wire pumpDownElapsed,
	input wire tempFault,
	// watched outputs
	input wire furnaceHeatEn,
	input wire gaugeHeatEn,
	input wire vapHeatEn,
	input wire pumpOn,
	input wire audioAlarm,
	input wire greenLamp
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (srst);
	// a ctrl write may start the run too, one edge later
	wire apbStart = psel && penable && pwrite && paddr == 8'h00 && pwdata[0];
	// vaporizer interlock as the controllers report it
	wire gateOk = basePressureLamp && !furnaceLimitLamp && !gaugeLimitLamp;
	sequence silenceReq;
		alarmPress && audioAlarm && clkEn;
	endsequence
	sequence heatDrop;
		$fell(furnaceHeatEn) && !semiAuto;
	endsequence
	chk_start_heat: assert property (
		$rose(furnaceHeatEn) && !semiAuto |-> $past(startStopPress) || $past(apbStart)
		|| $past(apbStart, 2)) else $error("heaters rose with no start");
	chk_vap_gate: assert property (
		$rose(vapHeatEn) |-> $past(gateOk)) else $error("vaporizer heat without interlock");
	chk_semi_pump: assert property (
		$rose(vapHeatEn) && $past(semiAuto) |-> $past(pumpDownElapsed))
		else $error("semi vaporizer before pump-down");
	chk_alarm_cause: assert property (
		$rose(audioAlarm) |-> $past(tempFault)) else $error("alarm with no fault");
	chk_silence_btn: assert property (
		silenceReq |=> !audioAlarm) else $error("alarm not silenced");
	chk_heater_off: assert property (
		heatDrop |-> !gaugeHeatEn && !vapHeatEn) else $error("heaters left on");
	chk_green_pump: assert property (
		greenLamp |-> pumpOn) else $error("pump off in hold");
	chk_press_blink: assert property (
		startStopPress && greenLamp && !furnaceHeatEn && clkEn && !semiAuto
		|=> !greenLamp [*2])
		else $error("blink kept after press");
endmodule // dps_seq_checker
bind dps_sequencer dps_seq_checker #(.FAULT_CYC(FAULT_CYC), .EOR_CYC(EOR_CYC),
	.BLINK_CYC(BLINK_CYC)) chk (.ref_clk, .srst, .clkEn, .psel, .penable, .pwrite,
	.paddr, .pwdata, .startStopPress, .alarmPress, .semiAuto, .basePressureLamp,
	.furnaceLimitLamp, .gaugeLimitLamp, .pumpDownElapsed, .tempFault, .furnaceHeatEn,
	.gaugeHeatEn, .vapHeatEn, .pumpOn, .audioAlarm, .greenLamp);

// *** test/dps_plant_model.sv ***
// Purpose: controllers and vaporizer seen from the sequencer
// Assumes: heaters warm in WARM cycles
// Notes: larger WARM gives a slow plant
`timescale 1ns/1ns
module dps_plant_model #(
	parameter int WARM = 8
) (
	// clock and reset
	input wire ref_clk,
	input wire srst,
	// heater drives
	input wire furnaceHeatEn,
	input wire vapHeatEn,
	// controller flags
	output wire basePressureLamp,
	output wire furnaceLimitLamp,
	output wire gaugeLimitLamp,
	output wire pumpDownElapsed,
	output reg [9:0] vapTempC
);
	int warm;
	// lamps settle only once the furnace has warmed
	assign basePressureLamp = warm == WARM;
	assign pumpDownElapsed = warm == WARM;
	assign furnaceLimitLamp = warm != WARM;
	assign gaugeLimitLamp = warm != WARM;
	// vaporizer climbs while heated, cools otherwise
	always @(posedge ref_clk) begin
		if (srst) begin
			warm <= 0;
			vapTempC <= 10'h014;
		end else begin
			warm <= !furnaceHeatEn ? 0 : (warm < WARM ? warm + 1 : warm);
			if (vapHeatEn && vapTempC < 10'h096)
				vapTempC <= vapTempC + 10'h001;
			else if (!vapHeatEn && vapTempC > 10'h014)
				vapTempC <= vapTempC - 10'h001;
		end
	end
endmodule // dps_plant_model

// *** test/tb.sv ***
// Purpose: self-checking bench of the sequencer
// Assumes: short timer parameters
// Notes: register rows first, then run scenarios
`timescale 1ns/1ns
`include "dps_seq_map.vh"
`define CHK(nm, ex, got) begin num_checks++; if ((got) !== (ex)) begin fails++; \
	$display("CHECK FAILED %s exp %h got %h", nm, ex, got); end end
`define WAITC(c, n) begin k = 0; while (!(c) && k < n) begin @(posedge ref_clk); k++; \
	end if (!(c)) begin fails++; give_verdict(); end #1; end
module tb;
	localparam [39:0] FCYC = 40'h28, ECYC = 40'h3c, BCYC = 40'h4;
	reg ref_clk = 0, srst = 1, psel = 0, penable = 0, pwrite = 0, err;
	reg [7:0] paddr = 8'h00;
	reg [31:0] pwdata = 32'h0, rd;
	reg startStopPress = 0, alarmPress = 0, ventSelect = 0, runComplete = 0;
	reg tempFault = 0, rotationFitted = 1, semiAuto = 0, manFurnaceEn = 0, manVapEn = 0;
	wire [31:0] prdata;
	wire [9:0] vapTempC;
	wire pready, pslverr, furnaceHeatEn, gaugeHeatEn, vapHeatEn, loadDoorHeatEn, vapLamp;
	wire rotateEn, pumpOn, redLamp, audioAlarm, greenLamp, irq;
	wire basePressureLamp, furnaceLimitLamp, gaugeLimitLamp, pumpDownElapsed;
	int fails = 0, num_checks = 0, i, k;
	// register rows: address, write, data, expected read, expected error
	typedef struct packed {bit [7:0] a; bit w; bit [31:0] d; bit [31:0] e; bit er;} dps_row_t;
	dps_row_t rows[6] = '{'{8'h04, 1, 32'h5, 0, 0}, '{8'h04, 0, 0, 0, 0},
		'{8'h08, 0, 0, 0, 0}, '{8'h0c, 1, 32'hf, 0, 0}, '{8'h0c, 0, 0, 32'hf, 0},
		'{8'h14, 0, 0, 0, 1}};
	dps_sequencer #(.FAULT_CYC(FCYC), .EOR_CYC(ECYC), .BLINK_CYC(BCYC)) uut (.ref_clk,
		.srst, .clkEn(1'b1), .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
		.pslverr, .startStopPress, .alarmPress, .ventSelect, .semiAuto,
		.rotationFitted, .basePressureLamp, .furnaceLimitLamp, .gaugeLimitLamp,
		.pumpDownElapsed, .runComplete, .tempFault, .vapTempC, .manFurnaceEn,
		.manVapEn, .manRotateEn(1'b0), .furnaceHeatEn, .gaugeHeatEn, .vapHeatEn,
		.loadDoorHeatEn, .vapLamp, .rotateEn, .pumpOn, .redLamp, .audioAlarm, .greenLamp,
		.irq);
	dps_plant_model #(.WARM(16)) plant (.ref_clk, .srst, .furnaceHeatEn, .vapHeatEn,
		.basePressureLamp, .furnaceLimitLamp, .gaugeLimitLamp, .pumpDownElapsed, .vapTempC);
	initial begin
		forever #2 ref_clk = ~ref_clk;
	end
	task automatic cyc(input int n);
		repeat (n) @(posedge ref_clk);
		#1;
	endtask
	// one apb transfer, held until pready is seen
	task automatic apb(input [7:0] a, input w, input [31:0] d);
		@(posedge ref_clk);
		psel <= 1;
		paddr <= a;
		pwrite <= w;
		pwdata <= d;
		@(posedge ref_clk);
		penable <= 1;
		// answer and error are taken at the edge where pready is seen, not after it
		k = 0;
		do begin
			@(posedge ref_clk);
			k++;
		end while (pready !== 1'b1 && k < 20);
		rd = prdata;
		err = pslverr;
		psel <= 0;
		penable <= 0;
		if (pready !== 1'b1) begin
			fails++;
			give_verdict();
		end
		#1;
	endtask
	task tapStart;
		@(posedge ref_clk);
		startStopPress <= 1;
		@(posedge ref_clk);
		startStopPress <= 0;
		#1;
	endtask
	task give_verdict;
		$display("checks %0d mismatches %0d", num_checks, fails);
		if (fails == 0 && num_checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	initial begin
		repeat (12) @(posedge ref_clk);
		srst <= 0;
		for (i = 0; i < 6; i++) begin
			apb(rows[i].a, rows[i].w, rows[i].d);
			if (!rows[i].w && !rows[i].er) `CHK("rdata", rows[i].e, rd)
			`CHK("pslverr", rows[i].er, err)
		end
		$display("register rows done");
		tapStart;
		`CHK("furnace", 1'b1, furnaceHeatEn)
		`CHK("vap off", 1'b0, vapHeatEn)
		`CHK("rotate", 1'b1, rotateEn)
		`WAITC(vapHeatEn, 200)
		`CHK("vap lamp", 1'b1, vapLamp)
		`WAITC(vapTempC > `DPS_COAT_TEMP_C, 200)
		apb(8'h04, 0, 0);
		`CHK("coat", `DPS_ST_COAT, rd[2:0])
		`CHK("irq", 1'b1, irq)
		apb(8'h10, 1, 32'hf);
		apb(8'h0c, 1, 32'h1);
		`CHK("irq off", 1'b0, irq)
		@(posedge ref_clk) tempFault <= 1;
		cyc(2);
		`CHK("audio", 1'b1, audioAlarm)
		`CHK("fault irq", 1'b1, irq)
		@(posedge ref_clk) alarmPress <= 1;
		@(posedge ref_clk) alarmPress <= 0;
		cyc(1);
		`CHK("silenced", 1'b0, audioAlarm)
		@(posedge ref_clk) tempFault <= 0;
		cyc(50);
		apb(8'h04, 0, 0);
		`CHK("resumed", `DPS_ST_COAT, rd[2:0])
		$display("fault recovery done");
		apb(8'h00, 1, 32'h4);
		cyc(1);
		`CHK("door on", 1'b1, loadDoorHeatEn)
		@(posedge ref_clk) tempFault <= 1;
		`WAITC(!furnaceHeatEn, 80)
		`CHK("grace", 1'b1, k > 30)
		`CHK("gauge off", 1'b0, gaugeHeatEn | vapHeatEn | loadDoorHeatEn)
		`CHK("pump", 1'b1, pumpOn)
		cyc(5);
		`CHK("red", 1'b1, redLamp)
		`WAITC(greenLamp, 20)
		`WAITC(!greenLamp, 20)
		@(posedge ref_clk) tempFault <= 0;
		tapStart;
		cyc(10);
		`CHK("blink end", 1'b0, greenLamp)
		$display("fault shutdown done");
		@(posedge ref_clk) rotationFitted <= 0;
		tapStart;
		`CHK("no rotate", 1'b0, rotateEn)
		`WAITC(vapHeatEn && vapTempC > `DPS_COAT_TEMP_C, 400)
		cyc(3);
		@(posedge ref_clk) runComplete <= 1;
		@(posedge ref_clk) runComplete <= 0;
		apb(8'h04, 0, 0);
		`CHK("hold", `DPS_ST_HOLD, rd[2:0])
		`CHK("vap held", 1'b1, vapHeatEn)
		`WAITC(!furnaceHeatEn, 100)
		`CHK("eor wait", 1'b1, k > 40)
		`CHK("no red", 1'b0, redLamp)
		@(posedge ref_clk) ventSelect <= 1;
		cyc(10);
		`CHK("vent", 1'b0, greenLamp)
		$display("end of run done");
		// semi-automatic: manual heaters, gated vaporizer, alarm trip
		@(posedge ref_clk) begin
			semiAuto <= 1;
			manFurnaceEn <= 1;
			manVapEn <= 1;
		end
		cyc(2);
		`CHK("semi lamp", 1'b1, vapLamp)
		`CHK("semi vap off", 1'b0, vapHeatEn)
		`WAITC(vapHeatEn, 40)
		`CHK("semi gauge", 1'b1, gaugeHeatEn)
		@(posedge ref_clk) tempFault <= 1;
		cyc(2);
		`CHK("semi audio", 1'b1, audioAlarm)
		`WAITC(!furnaceHeatEn, 80)
		`CHK("semi wait", 1'b1, k > 30)
		`CHK("semi heat off", 1'b0, gaugeHeatEn | vapHeatEn | loadDoorHeatEn)
		`CHK("semi red", 1'b1, redLamp)
		$display("semi-automatic done");
		give_verdict();
	end
endmodule // tb
